// [include/pdma_params.svh]
/*
 register offsets, bit positions and reset values of the peripheral dma channel pair.
 assumes nothing; definitions only.
*/
`ifndef PDMA_PARAMS_SVH
`define PDMA_PARAMS_SVH
`define PDMA_OFS_RX_ADDR 12'h100
`define PDMA_OFS_RX_CNT 12'h104
`define PDMA_OFS_TX_ADDR 12'h108
`define PDMA_OFS_TX_CNT 12'h10C
`define PDMA_OFS_RX_NADDR 12'h110
`define PDMA_OFS_RX_NCNT 12'h114
`define PDMA_OFS_TX_NADDR 12'h118
`define PDMA_OFS_TX_NCNT 12'h11C
`define PDMA_OFS_CTRL 12'h120
`define PDMA_OFS_STATE 12'h124
`define PDMA_OFS_FLAGS 12'h128
`define PDMA_OFS_SIZE 12'h12C
`define PDMA_BIT_RX_ON 0
`define PDMA_BIT_RX_OFF 1
`define PDMA_BIT_TX_ON 8
`define PDMA_BIT_TX_OFF 9
`define PDMA_BIT_RX_EN 0
`define PDMA_BIT_TX_EN 8
`define PDMA_BIT_RX_DONE 0
`define PDMA_BIT_RX_FULL 1
`define PDMA_BIT_TX_DONE 8
`define PDMA_BIT_TX_EMPTY 9
`define PDMA_RST_ADDR 32'h0000_0000
`define PDMA_RST_CNT 16'h0000
`define PDMA_RST_SIZE 2'h2
`define PDMA_UNMAPPED_DATA 32'h0000_0000
`endif

// [include/pdma_pkg.sv]
/*
 types shared by the peripheral dma channel pair.
 assumes nothing.
*/
package pdma_pkg;
    typedef enum logic [2:0] {
        PDMA_IDLE = 3'b001,
        PDMA_READ = 3'b010,
        PDMA_WRITE = 3'b100
    } pdma_state_t;
    typedef enum logic [1:0] {
        PDMA_BYTE = 2'h0,
        PDMA_HALF = 2'h1,
        PDMA_WORD = 2'h2
    } pdma_size_t;
endpackage

// [hdl/pdma_channel_pair.sv]
/*
 one receive/transmit peripheral dma channel pair with its register slave (avalon-mm)
 and a simple memory master doing one read then one write per transfer.
 assumes: peripheral ready levels are synchronous to clk; the memory master port
 answers with waitrequest; holding register access is done by the memory master too.
*/
// The implementer's own choice: the Avalon-MM slave port.
// What this block does
// (R1) receive pointer at 0x100, read-write
// (R2) receive counter at 0x104, low 16 bits
// (R3) transmit pointer at 0x108 gives fetch address
// (R4) transmit counter 0x10C; zero stops transmit
// (R5) receive next pointer 0x110 chains receive
// (R6) receive next counter 0x114, low 16 bits
// (R7) transmit next pointer 0x118 chains transmit
// (R8) transmit next counter 0x11C, low 16 bits
// (R9) control bit 0 enables receive unless bit1
// (R10) control bit 1 disables receive, wins
// (R11) control bit 8 enables transmit
// (R12) control bit 9 disables transmit
// (R13) status bit 0 shows receive enabled
// (R14) status bit 8 shows transmit enabled
// (R15) same ten registers at same offsets
// (R16) pointer steps 1/2/4, counter decrements
// (R17) zero counter loads next, clears next
// (R18) end flag at zero; full/empty both zero
// (R19) counter writes clear that end flag
// (R20) transmit on plus off means off
// (R21) request only enabled, nonzero, peripheral ready
`timescale 1ns/1ns
`include "pdma_params.svh"
module pdma_channel_pair #(
    parameter int ADDR_W = 12,
    parameter logic [31:0] RX_HOLD_ADDR = 32'h0000_0018,
    parameter logic [31:0] TX_HOLD_ADDR = 32'h0000_001C
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic peripheral_rx_ready,
    input wire logic peripheral_tx_ready,
    output logic [31:0] avm_address,
    output logic avm_read,
    output logic avm_write,
    output logic [31:0] avm_writedata,
    output logic [3:0] avm_byteenable,
    input wire logic [31:0] avm_readdata,
    input wire logic avm_waitrequest,
    output logic rx_buffer_done_flag,
    output logic tx_buffer_done_flag,
    output logic rx_all_buffers_full_flag,
    output logic tx_all_buffers_empty_flag
);
    import pdma_pkg::*;

    // offsets up to 0x12C need nine address bits
    if (ADDR_W < 9) begin : g_addr_w_check
        $error("ADDR_W must reach offset 0x12C");
    end

    // registers
    logic [31:0] rx_buffer_address;
    logic [15:0] rx_remaining_count;
    logic [31:0] tx_buffer_address;
    logic [15:0] tx_remaining_count;
    logic [31:0] rx_chained_address;
    logic [15:0] rx_chained_count;
    logic [31:0] tx_chained_address;
    logic [15:0] tx_chained_count;
    logic rx_enabled;
    logic tx_enabled;
    pdma_size_t rx_size;
    pdma_size_t tx_size;
    pdma_state_t state;
    logic active_tx;
    logic [31:0] data_hold;
    logic bus_done;

    // bus decode; one wait cycle then answer
    logic [11:0] ofs;
    logic wr_now;
    logic rd_now;
    assign ofs = 12'(avs_address);
    assign wr_now = avs_write && !bus_done;
    assign rd_now = avs_read && !bus_done;

    // byte lanes of a software write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pointer increment per transfer width
    function automatic logic [31:0] step(input pdma_size_t sz);
        unique case (sz)
            PDMA_BYTE: return 32'h0000_0001;
            PDMA_HALF: return 32'h0000_0002;
            default: return 32'h0000_0004;
        endcase
    endfunction

    logic wr_rx_addr, wr_rx_cnt, wr_tx_addr, wr_tx_cnt;
    logic wr_rx_naddr, wr_rx_ncnt, wr_tx_naddr, wr_tx_ncnt, wr_ctrl, wr_size;
    assign wr_rx_addr = wr_now && ofs == `PDMA_OFS_RX_ADDR; // R1 R15
    assign wr_rx_cnt = wr_now && ofs == `PDMA_OFS_RX_CNT; // R2
    assign wr_tx_addr = wr_now && ofs == `PDMA_OFS_TX_ADDR; // R3
    assign wr_tx_cnt = wr_now && ofs == `PDMA_OFS_TX_CNT; // R4
    assign wr_rx_naddr = wr_now && ofs == `PDMA_OFS_RX_NADDR; // R5
    assign wr_rx_ncnt = wr_now && ofs == `PDMA_OFS_RX_NCNT; // R6
    assign wr_tx_naddr = wr_now && ofs == `PDMA_OFS_TX_NADDR; // R7
    assign wr_tx_ncnt = wr_now && ofs == `PDMA_OFS_TX_NCNT; // R8
    assign wr_ctrl = wr_now && ofs == `PDMA_OFS_CTRL;
    assign wr_size = wr_now && ofs == `PDMA_OFS_SIZE;

    // transfer completion events
    logic xfer_end;
    logic rx_step;
    logic tx_step;
    assign xfer_end = state == PDMA_WRITE && !avm_waitrequest;
    assign rx_step = xfer_end && !active_tx;
    assign tx_step = xfer_end && active_tx;

    // a request needs enable, a nonzero count and peripheral ready
    logic rx_req;
    logic tx_req;
    assign rx_req = rx_enabled && rx_remaining_count != `PDMA_RST_CNT && peripheral_rx_ready; // R21
    assign tx_req = tx_enabled && tx_remaining_count != `PDMA_RST_CNT && peripheral_tx_ready; // R21 R4

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_done <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `PDMA_UNMAPPED_DATA;
        end else begin
            bus_done <= (avs_read || avs_write) && !bus_done;
            avs_waitrequest <= !((avs_read || avs_write) && !bus_done);
            if (rd_now) begin
                unique case (ofs)
                    `PDMA_OFS_RX_ADDR: avs_readdata <= rx_buffer_address; // R1
                    `PDMA_OFS_RX_CNT: avs_readdata <= {16'h0000, rx_remaining_count}; // R2
                    `PDMA_OFS_TX_ADDR: avs_readdata <= tx_buffer_address;
                    `PDMA_OFS_TX_CNT: avs_readdata <= {16'h0000, tx_remaining_count};
                    `PDMA_OFS_RX_NADDR: avs_readdata <= rx_chained_address;
                    `PDMA_OFS_RX_NCNT: avs_readdata <= {16'h0000, rx_chained_count};
                    `PDMA_OFS_TX_NADDR: avs_readdata <= tx_chained_address;
                    `PDMA_OFS_TX_NCNT: avs_readdata <= {16'h0000, tx_chained_count};
                    `PDMA_OFS_STATE: begin
                        avs_readdata <= 32'h0000_0000;
                        avs_readdata[`PDMA_BIT_RX_EN] <= rx_enabled; // R13
                        avs_readdata[`PDMA_BIT_TX_EN] <= tx_enabled; // R14
                    end
                    `PDMA_OFS_FLAGS: begin
                        avs_readdata <= 32'h0000_0000;
                        avs_readdata[`PDMA_BIT_RX_DONE] <= rx_buffer_done_flag;
                        avs_readdata[`PDMA_BIT_RX_FULL] <= rx_all_buffers_full_flag;
                        avs_readdata[`PDMA_BIT_TX_DONE] <= tx_buffer_done_flag;
                        avs_readdata[`PDMA_BIT_TX_EMPTY] <= tx_all_buffers_empty_flag;
                    end
                    `PDMA_OFS_SIZE: avs_readdata <= {20'h00000, 2'h0, tx_size, 6'h00, rx_size};
                    default: avs_readdata <= `PDMA_UNMAPPED_DATA;
                endcase
            end
        end
    end

    // enables: write-only control, disable wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_enabled <= 1'b0;
            tx_enabled <= 1'b0;
        end else if (wr_ctrl) begin
            if (avs_writedata[`PDMA_BIT_RX_OFF]) begin
                rx_enabled <= 1'b0; // R10
            end else if (avs_writedata[`PDMA_BIT_RX_ON]) begin
                rx_enabled <= 1'b1; // R9
            end
            if (avs_writedata[`PDMA_BIT_TX_OFF]) begin
                tx_enabled <= 1'b0; // R12 R20
            end else if (avs_writedata[`PDMA_BIT_TX_ON]) begin
                tx_enabled <= 1'b1; // R11
            end
        end
    end

    // transfer width per direction; code 3 acts as word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_size <= PDMA_WORD;
            tx_size <= PDMA_WORD;
        end else if (wr_size) begin
            rx_size <= (avs_writedata[1:0] == 2'h3) ? PDMA_WORD : pdma_size_t'(avs_writedata[1:0]);
            tx_size <= (avs_writedata[9:8] == 2'h3) ? PDMA_WORD : pdma_size_t'(avs_writedata[9:8]);
        end
    end

    // receive pointer and counters; software write wins over the step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_buffer_address <= `PDMA_RST_ADDR;
            rx_remaining_count <= `PDMA_RST_CNT;
            rx_chained_address <= `PDMA_RST_ADDR;
            rx_chained_count <= `PDMA_RST_CNT;
        end else begin
            if (rx_step) begin
                if (rx_remaining_count == 16'h0001) begin
                    rx_buffer_address <= rx_chained_address; // R17
                    rx_remaining_count <= rx_chained_count; // R17
                    rx_chained_count <= `PDMA_RST_CNT; // R17
                end else begin
                    rx_buffer_address <= rx_buffer_address + step(rx_size); // R16
                    rx_remaining_count <= rx_remaining_count - 16'h0001; // R16
                end
            end
            if (wr_rx_addr) begin
                rx_buffer_address <= merge(rx_buffer_address, avs_writedata, avs_byteenable);
            end
            if (wr_rx_cnt) begin
                rx_remaining_count <= merge({16'h0000, rx_remaining_count}, avs_writedata,
                                            avs_byteenable) >> 0 == 0 ? 16'h0000 :
                                      16'(merge({16'h0000, rx_remaining_count}, avs_writedata,
                                                avs_byteenable));
            end
            if (wr_rx_naddr) begin
                rx_chained_address <= merge(rx_chained_address, avs_writedata, avs_byteenable);
            end
            if (wr_rx_ncnt) begin
                rx_chained_count <= 16'(merge({16'h0000, rx_chained_count}, avs_writedata,
                                              avs_byteenable));
            end
        end
    end

    // transmit pointer and counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_buffer_address <= `PDMA_RST_ADDR;
            tx_remaining_count <= `PDMA_RST_CNT;
            tx_chained_address <= `PDMA_RST_ADDR;
            tx_chained_count <= `PDMA_RST_CNT;
        end else begin
            if (tx_step) begin
                if (tx_remaining_count == 16'h0001) begin
                    tx_buffer_address <= tx_chained_address; // R17
                    tx_remaining_count <= tx_chained_count; // R17
                    tx_chained_count <= `PDMA_RST_CNT; // R17
                end else begin
                    tx_buffer_address <= tx_buffer_address + step(tx_size); // R16
                    tx_remaining_count <= tx_remaining_count - 16'h0001; // R16
                end
            end
            if (wr_tx_addr) begin
                tx_buffer_address <= merge(tx_buffer_address, avs_writedata, avs_byteenable);
            end
            if (wr_tx_cnt) begin
                tx_remaining_count <= 16'(merge({16'h0000, tx_remaining_count}, avs_writedata,
                                                avs_byteenable));
            end
            if (wr_tx_naddr) begin
                tx_chained_address <= merge(tx_chained_address, avs_writedata, avs_byteenable);
            end
            if (wr_tx_ncnt) begin
                tx_chained_count <= 16'(merge({16'h0000, tx_chained_count}, avs_writedata,
                                              avs_byteenable));
            end
        end
    end

    // flags follow the counters; a counter write clears the end flag
    logic rx_hit_zero;
    logic tx_hit_zero;
    assign rx_hit_zero = rx_step && rx_remaining_count == 16'h0001;
    assign tx_hit_zero = tx_step && tx_remaining_count == 16'h0001;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_buffer_done_flag <= 1'b0;
            tx_buffer_done_flag <= 1'b0;
            rx_all_buffers_full_flag <= 1'b0;
            tx_all_buffers_empty_flag <= 1'b0;
        end else begin
            // a hardware set wins over a clearing counter write
            if (rx_hit_zero) begin
                rx_buffer_done_flag <= 1'b1; // R18
            end else if (wr_rx_cnt || wr_rx_ncnt) begin
                rx_buffer_done_flag <= 1'b0; // R19
            end
            if (tx_hit_zero) begin
                tx_buffer_done_flag <= 1'b1; // R18
            end else if (wr_tx_cnt || wr_tx_ncnt) begin
                tx_buffer_done_flag <= 1'b0; // R19
            end
            rx_all_buffers_full_flag <= rx_remaining_count == `PDMA_RST_CNT
                                        && rx_chained_count == `PDMA_RST_CNT; // R18
            tx_all_buffers_empty_flag <= tx_remaining_count == `PDMA_RST_CNT
                                         && tx_chained_count == `PDMA_RST_CNT; // R18
        end
    end

    // memory master: receive first, then transmit
    function automatic logic [3:0] lanes(input pdma_size_t sz, input logic [1:0] a);
        unique case (sz)
            PDMA_BYTE: return 4'h1 << a;
            PDMA_HALF: return a[1] ? 4'hC : 4'h3;
            default: return 4'hF;
        endcase
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= PDMA_IDLE;
            active_tx <= 1'b0;
            data_hold <= 32'h0000_0000;
            avm_address <= 32'h0000_0000;
            avm_read <= 1'b0;
            avm_write <= 1'b0;
            avm_writedata <= 32'h0000_0000;
            avm_byteenable <= 4'h0;
        end else begin
            unique case (state)
                PDMA_IDLE: begin
                    if (rx_req) begin
                        state <= PDMA_READ;
                        active_tx <= 1'b0;
                        avm_address <= RX_HOLD_ADDR;
                        avm_byteenable <= 4'hF;
                        avm_read <= 1'b1;
                    end else if (tx_req) begin
                        state <= PDMA_READ;
                        active_tx <= 1'b1;
                        avm_address <= tx_buffer_address; // R3
                        avm_byteenable <= lanes(tx_size, tx_buffer_address[1:0]);
                        avm_read <= 1'b1;
                    end
                end
                PDMA_READ: begin
                    if (!avm_waitrequest) begin
                        data_hold <= avm_readdata;
                        avm_read <= 1'b0;
                        avm_write <= 1'b1;
                        avm_writedata <= avm_readdata;
                        state <= PDMA_WRITE;
                        if (active_tx) begin
                            avm_address <= TX_HOLD_ADDR;
                            avm_byteenable <= 4'hF;
                        end else begin
                            avm_address <= rx_buffer_address; // R1
                            avm_byteenable <= lanes(rx_size, rx_buffer_address[1:0]);
                        end
                    end
                end
                PDMA_WRITE: begin
                    if (!avm_waitrequest) begin
                        avm_write <= 1'b0;
                        state <= PDMA_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [verification/pdma_mem_model.sv]
/*
 memory slave partner for the channel pair master port, logging every write.
 assumes read and write are held until waitrequest is seen low.
*/
`timescale 1ns/1ns
module pdma_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [31:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [31:0] avm_writedata,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    output logic [31:0] last_waddr,
    output logic [31:0] last_wdata,
    output int wr_count
);
    logic [1:0] hold;
    // answers at once, or after three stalled cycles when slow
    assign avm_waitrequest = !((avm_read || avm_write) && (!slow || hold == 2'h3));
    // data only while answering a read, else the inverse pattern
    assign avm_readdata = (avm_read && !avm_waitrequest) ? avm_address ^ 32'h5A5A_0000
        : ~avm_address;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold <= 2'h0;
            wr_count <= 0;
            last_waddr <= 32'h0000_0000;
            last_wdata <= 32'h0000_0000;
        end else begin
            hold <= (avm_waitrequest && (avm_read || avm_write)) ? hold + 2'h1 : 2'h0;
            if (avm_write && !avm_waitrequest) begin
                wr_count <= wr_count + 1;
                last_waddr <= avm_address;
                last_wdata <= avm_writedata;
            end
        end
    end
endmodule

// [verification/pdma_channel_pair_props.sv]
/*
 concurrent checks of the channel pair at its top-level ports.
 assumes the design's port names and parameters; bound at the foot.
*/
`timescale 1ns/1ns
`include "pdma_params.svh"
module pdma_channel_pair_props #(
    parameter int ADDR_W = 12,
    parameter logic [31:0] RX_HOLD_ADDR = 32'h0000_0018
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic peripheral_rx_ready,
    input wire logic peripheral_tx_ready,
    input wire logic [31:0] avm_address,
    input wire logic avm_read,
    input wire logic avm_write,
    input wire logic [31:0] avm_writedata,
    input wire logic avm_waitrequest,
    input wire logic rx_buffer_done_flag,
    input wire logic rx_all_buffers_full_flag,
    input wire logic tx_all_buffers_empty_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_bus_answer: assert property (
        $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("register answer timing wrong");
    a_master_excl: assert property (
        !(avm_read && avm_write)) else $error("memory read and write together");
    a_read_then_write: assert property (
        $fell(avm_read) |-> avm_write) else $error("read not followed by write");
    a_request_hold: assert property (
        (avm_read || avm_write) && avm_waitrequest |=> $stable(avm_address)
        && $stable(avm_writedata) && $stable(avm_read) && $stable(avm_write))
        else $error("memory request changed while stalled");
    a_req_needs_ready: assert property (
        $rose(avm_read) |-> $past(peripheral_rx_ready || peripheral_tx_ready))
        else $error("transfer without peripheral ready");
    a_rx_full_idle: assert property (
        $rose(avm_read) && avm_address == RX_HOLD_ADDR |-> !rx_all_buffers_full_flag)
        else $error("receive transfer with no buffer left");
    a_tx_empty_idle: assert property (
        $rose(avm_read) && avm_address != RX_HOLD_ADDR |-> !tx_all_buffers_empty_flag)
        else $error("transmit transfer with zero count");
    a_rx_done_sticky: assert property (
        rx_buffer_done_flag && !(avs_write && (avs_address == `PDMA_OFS_RX_CNT
        || avs_address == `PDMA_OFS_RX_NCNT)) |=> rx_buffer_done_flag)
        else $error("receive end flag lost without counter write");
endmodule
bind pdma_channel_pair pdma_channel_pair_props #(
    .ADDR_W(ADDR_W), .RX_HOLD_ADDR(RX_HOLD_ADDR)) u_props (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .peripheral_rx_ready(peripheral_rx_ready), .peripheral_tx_ready(peripheral_tx_ready),
    .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write),
    .avm_writedata(avm_writedata), .avm_waitrequest(avm_waitrequest),
    .rx_buffer_done_flag(rx_buffer_done_flag),
    .rx_all_buffers_full_flag(rx_all_buffers_full_flag),
    .tx_all_buffers_empty_flag(tx_all_buffers_empty_flag));

// [verification/pdma_channel_pair_tb.sv]
/*
 self-checking bench: register access over avalon-mm, enable control, chained transfers.
 assumes the memory partner model and the bound checker.
*/
`timescale 1ns/1ns
`include "pdma_params.svh"
module pdma_channel_pair_tb;
    localparam logic [31:0] RXH = 32'h0000_0F00;
    localparam logic [31:0] TXH = 32'h0000_0F04;
    localparam logic [31:0] P = 32'h5A5A_0000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic rx_rdy = 1'b0;
    logic tx_rdy = 1'b0;
    logic slow = 1'b0;
    logic avs_waitrequest, avm_read, avm_write, avm_waitrequest, rx_done;
    logic tx_done, rx_full, tx_empty;
    logic [3:0] avm_be;
    logic [3:0] last_be = 4'h0;
    logic [31:0] avs_readdata, avm_address, avm_writedata, avm_readdata, q;
    logic [31:0] last_waddr, last_wdata;
    int wr_count;
    int err_total = 0;
    int comparisons = 0;
    logic [11:0] cv [8] = '{12'h001, 12'h000, 12'h003, 12'h001,
        12'h100, 12'h000, 12'h300, 12'h202};
    logic [11:0] sv [8] = '{12'h001, 12'h001, 12'h000, 12'h001,
        12'h101, 12'h101, 12'h001, 12'h000};
    always #5 clk = ~clk;
    pdma_channel_pair #(.ADDR_W(12), .RX_HOLD_ADDR(RXH), .TX_HOLD_ADDR(TXH)) uut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .peripheral_rx_ready(rx_rdy), .peripheral_tx_ready(tx_rdy),
        .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write),
        .avm_writedata(avm_writedata), .avm_byteenable(avm_be), .avm_readdata(avm_readdata),
        .avm_waitrequest(avm_waitrequest), .rx_buffer_done_flag(rx_done),
        .tx_buffer_done_flag(tx_done), .rx_all_buffers_full_flag(rx_full),
        .tx_all_buffers_empty_flag(tx_empty));
    pdma_mem_model mem (
        .clk(clk), .rst(rst), .slow(slow), .avm_address(avm_address), .avm_read(avm_read),
        .avm_write(avm_write), .avm_writedata(avm_writedata), .avm_readdata(avm_readdata),
        .avm_waitrequest(avm_waitrequest), .last_waddr(last_waddr),
        .last_wdata(last_wdata), .wr_count(wr_count));
    // lanes of the last accepted memory write
    always @(posedge clk) begin
        if (avm_write && !avm_waitrequest) begin
            last_be <= avm_be;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one request held until waitrequest is sampled low, then released
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0000_0000);
        chk(q, e);
    endtask
    // waits for the n-th memory write and checks where it went and what it carried
    task automatic got(input int n, input logic [31:0] a, input logic [31:0] d);
        while (wr_count != n) @(posedge clk);
        chk(last_waddr, a);
        chk(last_wdata, d);
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd(12'h100 + 12'(4 * i), 32'h0);
        rd(12'h130, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            wr(12'h100 + 12'(4 * i), 32'hFFFF_FFFF);
            rd(12'h100 + 12'(4 * i), i[0] ? 32'h0000_FFFF : 32'hFFFF_FFFF);
            wr(12'h100 + 12'(4 * i), 32'h0000_0000);
        end
        for (int i = 0; i < 8; i++) begin
            wr(`PDMA_OFS_CTRL, {20'h0_0000, cv[i]});
            rd(`PDMA_OFS_STATE, {20'h0_0000, sv[i]});
        end
        rd(`PDMA_OFS_CTRL, 32'h0000_0000);
        wr(`PDMA_OFS_SIZE, 32'h0000_0100);
        wr(`PDMA_OFS_RX_ADDR, 32'h0000_1000);
        wr(`PDMA_OFS_RX_CNT, 32'h0000_0002);
        wr(`PDMA_OFS_RX_NADDR, 32'h0000_2000);
        wr(`PDMA_OFS_RX_NCNT, 32'h0000_0001);
        wr(`PDMA_OFS_CTRL, 32'h0000_0001);
        slow <= 1'b1;
        rx_rdy <= 1'b1;
        tx_rdy <= 1'b1;
        got(1, 32'h0000_1000, RXH ^ P);
        got(2, 32'h0000_1001, RXH ^ P);
        chk({28'h0, last_be}, 32'h0000_0002);
        got(3, 32'h0000_2000, RXH ^ P);
        repeat (20) @(posedge clk);
        chk(32'(wr_count), 32'h0000_0003);
        rd(`PDMA_OFS_RX_NCNT, 32'h0000_0000);
        rd(`PDMA_OFS_FLAGS, 32'h0000_0203);
        chk({28'h0, tx_empty, tx_done, rx_full, rx_done}, 32'h0000_000B);
        wr(`PDMA_OFS_RX_NCNT, 32'h0000_0000);
        rd(`PDMA_OFS_FLAGS, 32'h0000_0202);
        slow <= 1'b0;
        wr(`PDMA_OFS_TX_ADDR, 32'h0000_3000);
        wr(`PDMA_OFS_TX_CNT, 32'h0000_0001);
        wr(`PDMA_OFS_TX_NADDR, 32'h0000_4000);
        wr(`PDMA_OFS_TX_NCNT, 32'h0000_0001);
        wr(`PDMA_OFS_CTRL, 32'h0000_0100);
        got(4, TXH, 32'h0000_3000 ^ P);
        got(5, TXH, 32'h0000_4000 ^ P);
        repeat (20) @(posedge clk);
        chk(32'(wr_count), 32'h0000_0005);
        rd(`PDMA_OFS_FLAGS, 32'h0000_0302);
        chk({28'h0, tx_empty, tx_done, rx_full, rx_done}, 32'h0000_000E);
        wr(`PDMA_OFS_CTRL, 32'h0000_0200);
        wr(`PDMA_OFS_TX_ADDR, 32'h0000_5000);
        wr(`PDMA_OFS_TX_CNT, 32'h0000_0002);
        rd(`PDMA_OFS_FLAGS, 32'h0000_0002);
        repeat (20) @(posedge clk);
        chk(32'(wr_count), 32'h0000_0005);
        wr(`PDMA_OFS_CTRL, 32'h0000_0100);
        got(6, TXH, 32'h0000_5000 ^ P);
        got(7, TXH, 32'h0000_5002 ^ P);
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        results();
    end
endmodule
